//--- watch_and_interval_timers.sv
// Purpose: watch timer with half-second interrupt and divided interval timer on a shared count chain
// Assumes: subclock arrives as sub_clk_tick, one ref_clk cycle wide; software keeps its own constraints
// Notes:   the shared 9-bit chain is phase-free to the watch start, which gives the first-interrupt latency

`timescale 1ns/1ps

module watch_and_interval_timers (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // subclock tick
  input  wire logic        sub_clk_tick,
  // watch mode bits
  input  wire logic        interval_run_bit,
  input  wire logic        watch_run_bit,
  input  wire logic        watch_config_low,
  input  wire logic        watch_config_high,
  input  wire logic [2:0]  interval_select,
  // prescaler mode bits
  input  wire logic        prescaler_count_enable,
  input  wire logic        prescaler_clock_sel_hi,
  input  wire logic        prescaler_clock_sel_lo,
  input  wire logic        tick_output_disable,
  input  wire logic [7:0]  prescaler_interval,
  // events and status
  output logic             watch_tick_irq,
  output logic             interval_tick_irq,
  output logic             prescaler_tick_out,
  output logic             watch_counting
);
  // --------------------------------------------------------------------------
  // prescaler interval timer
  // --------------------------------------------------------------------------
  logic pre_tick;

  prescaler_interval_timer u_prescaler (
    .ref_clk                (ref_clk),
    .rst                    (rst),
    .clk_en                 (clk_en),
    .prescaler_count_enable (prescaler_count_enable),
    .prescaler_clock_sel_hi (prescaler_clock_sel_hi),
    .prescaler_clock_sel_lo (prescaler_clock_sel_lo),
    .prescaler_interval     (prescaler_interval),
    .tick                   (pre_tick)
  );

  // --------------------------------------------------------------------------
  // shared count chain and divided interval timer
  // --------------------------------------------------------------------------
  // watch_config_low picks the subclock; otherwise the prescaler tick, which
  // software must hold near 32.768 kHz for a true half second
  logic                         src_tick;
  logic [watch_pkg::CHAIN_W-1:0] chain;
  logic [watch_pkg::CHAIN_W-1:0] next_chain;
  logic [15:0]                  div_count;
  logic [15:0]                  next_div_count;
  logic                         chain_carry;
  logic                         next_interval_irq;
  logic [4:0]                   sel_bits;

  // with the subclock selected the prescaler tick never reaches the chain
  assign src_tick = watch_config_low ? sub_clk_tick : pre_tick;

  always_comb begin
    next_chain        = chain;
    next_div_count    = div_count;
    next_interval_irq = 1'b0;
    chain_carry       = 1'b0;
    sel_bits          = 5'(interval_select) + 5'(watch_pkg::SEL_BASE);
    if (!interval_run_bit) begin
      // stopping the chain loses its phase, so a restart slips the watch
      next_chain     = watch_pkg::CHAIN_RESET;
      next_div_count = 16'h0000;
    end else if (src_tick) begin
      next_chain  = chain + 9'h001;
      chain_carry = (chain == 9'h1ff);
      // select may change on the fly; the running count is compared against the new width at once
      if (watch_pkg::low_ones(div_count, sel_bits)) begin
        next_interval_irq = 1'b1;
        next_div_count    = 16'h0000;
      end else begin
        next_div_count = div_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chain             <= watch_pkg::CHAIN_RESET;
      div_count         <= 16'h0000;
      interval_tick_irq <= 1'b0;
    end else if (clk_en) begin
      chain             <= next_chain;
      div_count         <= next_div_count;
      interval_tick_irq <= next_interval_irq;
    end
  end

  // --------------------------------------------------------------------------
  // watch timer
  // --------------------------------------------------------------------------
  watch_pkg::watch_state_type        state;
  watch_pkg::watch_state_type        next_state;
  logic [watch_pkg::WATCH_CNT_W-1:0] watch_cnt;
  logic [watch_pkg::WATCH_CNT_W-1:0] next_watch_cnt;
  logic                              next_watch_irq;
  logic [watch_pkg::WATCH_CNT_W-1:0] watch_last;
  logic                              running;

  always_comb begin
    next_state     = state;
    next_watch_cnt = watch_cnt;
    next_watch_irq = 1'b0;
    running        = watch_run_bit && interval_run_bit;
    // the high config bit shortens the period to a quarter second
    watch_last     = watch_config_high ? watch_pkg::WATCH_LAST_QUART : watch_pkg::WATCH_LAST_HALF;
    case (state)
      watch_pkg::watch_idle: begin
        next_watch_cnt = watch_pkg::WATCH_RESET;
        if (running) begin
          next_state = watch_pkg::watch_first;
        end
      end
      watch_pkg::watch_first, watch_pkg::watch_periodic: begin
        if (!running) begin
          next_state     = watch_pkg::watch_idle;
          next_watch_cnt = watch_pkg::WATCH_RESET;
        end else if (chain_carry) begin
          // the first carry may come up to 512 ticks late, not later
          if (watch_cnt == watch_last) begin
            next_watch_cnt = watch_pkg::WATCH_RESET;
            next_watch_irq = 1'b1;
            next_state     = watch_pkg::watch_periodic;
          end else begin
            next_watch_cnt = watch_cnt + 5'h01;
          end
        end
      end
      default: begin
        next_state     = watch_pkg::watch_idle;
        next_watch_cnt = watch_pkg::WATCH_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state              <= watch_pkg::watch_idle;
      watch_cnt          <= watch_pkg::WATCH_RESET;
      watch_tick_irq     <= 1'b0;
      watch_counting     <= 1'b0;
      prescaler_tick_out <= 1'b0;
    end else if (clk_en) begin
      state              <= next_state;
      watch_cnt          <= next_watch_cnt;
      watch_tick_irq     <= next_watch_irq;
      watch_counting     <= (next_state != watch_pkg::watch_idle);
      prescaler_tick_out <= pre_tick && !tick_output_disable;
    end
  end
endmodule

//--- watch_pkg.sv
// Purpose: shared constants for the watch and interval timers, plus the prescaler interval timer
// Assumes: ref_clk at 10 MHz, subclock arrives as a one-cycle tick synchronous to ref_clk
// Notes:   the prescaler is instantiated by watch_and_interval_timers

// ----------------------------------------------------------------------------
// constants
// ----------------------------------------------------------------------------
package watch_pkg;
  localparam int          REF_HZ            = 10000000;
  localparam int          SUB_HZ            = 32768;
  localparam int          WATCH_PERIOD_MS   = 500;
  localparam int          WATCH_QUARTER_MS  = 250;
  localparam int          FIRST_MAX_US      = 515625;
  localparam int          SLIP_US           = 15625;
  // source ticks per watch period, derived from the subclock rate
  localparam int          WATCH_TICKS       = SUB_HZ * WATCH_PERIOD_MS / 1000;
  localparam int          QUARTER_TICKS     = SUB_HZ * WATCH_QUARTER_MS / 1000;
  localparam int          SLIP_TICKS        = SUB_HZ / 1000 * SLIP_US / 1000 + 1;
  localparam int          CHAIN_W           = 9;
  localparam int          WATCH_CNT_W       = 5;
  localparam int          PRE_CNT_W         = 8;
  localparam int          PRE_DIV_W         = 3;
  localparam int          SEL_BASE          = 5;
  localparam logic [4:0]  WATCH_LAST_HALF   = 5'h1f;
  localparam logic [4:0]  WATCH_LAST_QUART  = 5'h0f;
  localparam logic [8:0]  CHAIN_RESET       = 9'h000;
  localparam logic [4:0]  WATCH_RESET       = 5'h00;
  localparam logic [7:0]  PRE_CNT_RESET     = 8'h00;
  localparam logic [2:0]  PRE_DIV_RESET     = 3'h0;

  typedef enum logic [2:0] {
    watch_idle     = 3'b001,
    watch_first    = 3'b010,
    watch_periodic = 3'b100
  } watch_state_type;

  // true when the low (n) bits of value are all ones; n = 0 always hits
  function automatic logic low_ones(input logic [15:0] value, input logic [4:0] n);
    logic [15:0] mask;
    mask = (16'h0001 << n) - 16'h0001;
    return (value & mask) == mask;
  endfunction
endpackage

//--- prescaler_interval_timer.sv
// Purpose: prescaler interval timer, an 8-bit compare counter behind a power-of-two clock divider
// Assumes: clock select and tick-output-disable are stable while count enable is high
// Notes:   tick period is (interval + 1) divided ref_clk periods

`timescale 1ns/1ps

module prescaler_interval_timer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // control
  input  wire logic        prescaler_count_enable,
  input  wire logic        prescaler_clock_sel_hi,
  input  wire logic        prescaler_clock_sel_lo,
  input  wire logic [7:0]  prescaler_interval,
  // tick out
  output logic             tick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic [2:0] div;
  logic [2:0] next_div;
  logic       next_tick;
  logic       base_hit;

  always_comb begin
    next_count = count;
    next_div   = div + 3'h1;
    next_tick  = 1'b0;
    base_hit   = watch_pkg::low_ones({13'h0000, div}, {3'h0, prescaler_clock_sel_hi, prescaler_clock_sel_lo});
    if (!prescaler_count_enable) begin
      // clearing the enable drops the counter to zero at once
      next_count = watch_pkg::PRE_CNT_RESET;
      next_div   = watch_pkg::PRE_DIV_RESET;
    end else if (base_hit) begin
      if (count == prescaler_interval) begin
        next_count = watch_pkg::PRE_CNT_RESET;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= watch_pkg::PRE_CNT_RESET;
      div   <= watch_pkg::PRE_DIV_RESET;
      tick  <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      div   <= next_div;
      tick  <= next_tick;
    end
  end
endmodule

//--- watch_timers_sva.sv
// Purpose: concurrent checks on the watch and interval timer ports
// Assumes: single ref_clk domain, rst asynchronous active high
// Notes:   gap counter keeps the watch spacing check cheap to unroll
`timescale 1ns/1ps
module watch_timers_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // control
  input wire logic interval_run_bit,
  input wire logic watch_run_bit,
  input wire logic prescaler_count_enable,
  // events and status
  input wire logic watch_tick_irq,
  input wire logic interval_tick_irq,
  input wire logic prescaler_tick_out,
  input wire logic watch_counting
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] gap;
  logic [15:0] next_gap;
  // --------------------------------------------------------------------------
  // cycles since watch start or last watch interrupt
  // --------------------------------------------------------------------------
  always_comb begin
    next_gap = (!watch_counting || watch_tick_irq) ? 16'h0000 : gap + 16'h0001;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) gap <= 16'h0000;
    else gap <= next_gap;
  end
  a_watch_start_gate: assert property ($rose(watch_counting) |-> $past(interval_run_bit && watch_run_bit))
    else $error("watch started without both run bits");
  a_watch_start_prompt: assert property (clk_en && interval_run_bit && watch_run_bit && !watch_counting |=>
    watch_counting) else $error("watch did not start one cycle after both run bits");
  a_stopped_no_irq: assert property (!interval_run_bit [*3] |-> !interval_tick_irq && !watch_tick_irq)
    else $error("interrupt while interval run bit low");
  a_watch_irq_pulse: assert property (watch_tick_irq |=> !watch_tick_irq)
    else $error("watch interrupt wider than one cycle");
  a_watch_irq_running: assert property (watch_tick_irq |-> $past(watch_counting))
    else $error("watch interrupt while watch idle");
  a_watch_gap_min: assert property (watch_tick_irq |-> gap >= 16'h1000)
    else $error("watch interrupts too close together");
  a_interval_gap_min: assert property (interval_tick_irq |=> !interval_tick_irq [*8])
    else $error("interval interrupts closer than the shortest period");
  a_prescaler_cleared: assert property (!prescaler_count_enable [*3] |-> !prescaler_tick_out)
    else $error("prescaler ticks while disabled");
endmodule
bind watch_and_interval_timers watch_timers_sva watch_timers_sva_inst (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .interval_run_bit(interval_run_bit), .watch_run_bit(watch_run_bit),
  .prescaler_count_enable(prescaler_count_enable), .watch_tick_irq(watch_tick_irq),
  .interval_tick_irq(interval_tick_irq), .prescaler_tick_out(prescaler_tick_out), .watch_counting(watch_counting));

//--- watch_and_interval_timers_bench.sv
// Purpose: self-checking bench for the watch and interval timers
// Assumes: prescaler at interval 0 gives one source tick per ref_clk cycle
// Notes:   counts are measured in cycles between pulses sampled at falling edges
`timescale 1ns/1ps
module watch_and_interval_timers_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sub_clk_tick = 1'b0;
  logic sub_en = 1'b0;
  logic clk_en = 1'b1;
  logic interval_run_bit, watch_run_bit, watch_config_low, watch_config_high;
  logic prescaler_count_enable, prescaler_clock_sel_hi, prescaler_clock_sel_lo, tick_output_disable;
  logic [2:0] interval_select;
  logic [7:0] prescaler_interval;
  logic watch_tick_irq, interval_tick_irq, prescaler_tick_out, watch_counting;
  int err_total = 0;
  int cmp_count = 0;
  int n, m, t0;
  always #50 ref_clk = ~ref_clk;
  // subclock stand-in: one-cycle tick every second cycle
  always @(posedge ref_clk) sub_clk_tick <= sub_en && !sub_clk_tick;
  watch_and_interval_timers watch_and_interval_timers_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .sub_clk_tick(sub_clk_tick), .interval_run_bit(interval_run_bit), .watch_run_bit(watch_run_bit),
    .watch_config_low(watch_config_low), .watch_config_high(watch_config_high), .interval_select(interval_select),
    .prescaler_count_enable(prescaler_count_enable), .prescaler_clock_sel_hi(prescaler_clock_sel_hi),
    .prescaler_clock_sel_lo(prescaler_clock_sel_lo), .tick_output_disable(tick_output_disable),
    .prescaler_interval(prescaler_interval), .watch_tick_irq(watch_tick_irq),
    .interval_tick_irq(interval_tick_irq), .prescaler_tick_out(prescaler_tick_out), .watch_counting(watch_counting));
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int which);
    case (which)
      0: return watch_tick_irq;
      1: return interval_tick_irq;
      default: return prescaler_tick_out;
    endcase
  endfunction
  // bounded wait for the next pulse; a limit hit shows up as a failed compare
  task automatic wait_for(input int which, input int limit, output int cnt);
    cnt = 0;
    do begin
      @(negedge ref_clk);
      cnt++;
    end while (pick(which) !== 1'b1 && cnt < limit);
    check(pick(which), 1'b1);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    {interval_run_bit, watch_run_bit, watch_config_low, watch_config_high} = 4'h0;
    {prescaler_count_enable, prescaler_clock_sel_hi, prescaler_clock_sel_lo, tick_output_disable} = 4'h0;
    interval_select = 3'h0;
    prescaler_interval = 8'h03;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    prescaler_count_enable <= 1'b1;
    wait_for(2, 50, t0);
    repeat (6) @(posedge ref_clk);
    prescaler_count_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    prescaler_count_enable <= 1'b1;
    wait_for(2, 50, n);
    check(n, t0);
    prescaler_count_enable <= 1'b0;
    @(posedge ref_clk);
    prescaler_interval <= 8'h00;
    @(posedge ref_clk);
    prescaler_count_enable <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      interval_run_bit <= 1'b0;
      interval_select <= s[2:0];
      repeat (2) @(posedge ref_clk);
      interval_run_bit <= 1'b1;
      wait_for(1, 9000, n);
      wait_for(1, 9000, m);
      check(m, 32'h20 << s);
    end
    @(posedge ref_clk);
    interval_run_bit <= 1'b0;
    interval_select <= 3'h0;
    watch_run_bit <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check(watch_counting, 1'b0);
    interval_run_bit <= 1'b1;
    wait_for(0, 17400, n);
    check(watch_counting, 1'b1);
    check(n >= 15872 && n <= 16900, 1'b1);
    wait_for(0, 17400, m);
    check(m, 32'h4000);
    @(posedge ref_clk);
    {interval_run_bit, watch_run_bit} <= 2'b00;
    @(posedge ref_clk);
    watch_config_low <= 1'b1;
    sub_en <= 1'b1;
    @(posedge ref_clk);
    interval_run_bit <= 1'b1;
    wait_for(1, 200, n);
    @(posedge ref_clk);
    prescaler_count_enable <= 1'b0;
    @(posedge ref_clk);
    prescaler_interval <= 8'h05;
    @(posedge ref_clk);
    prescaler_count_enable <= 1'b1;
    wait_for(1, 200, n);
    wait_for(1, 200, m);
    check(m, 32'h40);
    // clock enable low must freeze the interval count, so no pulse and a delayed next one
    @(posedge ref_clk);
    clk_en <= 1'b0;
    n = 0;
    repeat (100) begin
      @(negedge ref_clk);
      n += interval_tick_irq;
    end
    check(n, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_for(1, 200, n);
    check(n >= 60 && n <= 66, 1'b1);
    // tick output disable set before enable must keep the tick pin quiet
    @(posedge ref_clk);
    prescaler_count_enable <= 1'b0;
    @(posedge ref_clk);
    tick_output_disable <= 1'b1;
    @(posedge ref_clk);
    prescaler_count_enable <= 1'b1;
    n = 0;
    repeat (50) begin
      @(negedge ref_clk);
      n += prescaler_tick_out;
    end
    check(n, 32'h0);
    give_verdict();
  end
  initial begin
    #(100 * 80000);
    err_total++;
    give_verdict();
  end
endmodule
